// [hw/dmw_top.sv]
// Downstream memory window 2 and 3 base registers with APB access
// Functional notes
// - Window 3 type field reads 00 for 32-bit, 01 for 64-bit decode.
// - Window 2 type field always reads 32-bit; other codes unused.
// - Bit 3 is read-only prefetchable flag, reset to zero.
// - Window 2 size and prefetch flag follow its setup register at 00Ch.
// - Window 3 size and type follow its setup register at 014h.
// - Setup values come from outside loaders; the block applies them.
// - Window 2 setup bit 31 clear disables window 2.
// - Window 3 disabled by clearing bit 31 of setup 014h, or of 018h in 64-bit mode.
// - Base bits 31:12 writable only where setup bit is one.
// - Window 2 decodes 4KB to 2GB, memory space only.
// - Window 3 decodes 4KB up to 2GB of memory; setup 014h bit 31 stays compared in 64-bit mode.
// - Window 2 translates using translated base at 008h.
// - Window 3 in 32-bit mode translates using base at 010h.
// - Window 3 in 64-bit mode forwards addresses untouched.
`timescale 1ns/1ps
`include "dmw_cfg.svh"
module dmw_top
   import dmw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [31:0] win2_setup,
   input  wire logic [31:0] win2_xlat_base,
   input  wire logic [31:0] win3_setup_lo,
   input  wire logic [31:0] win3_setup_hi,
   input  wire logic [31:0] win3_xlat_base,
   input  wire logic [31:0] win3_upper_base,
   input  wire logic        req_valid,
   input  wire logic [63:0] req_addr,
   output logic             win2_valid,
   output logic             win2_hit,
   output logic [63:0]      win2_addr,
   output logic             win3_valid,
   output logic             win3_hit,
   output logic [63:0]      win3_addr
);
   dmw_state_t state;
   dmw_base_t  win2_base;
   dmw_base_t  win3_base;
   dmw_base_t  win2_mask;
   dmw_base_t  win3_mask;
   logic       win2_pref;
   logic       win3_pref;
   dmw_atype_t win3_type;
   logic       win2_en;
   logic       win3_en;
   logic       win3_is64;
   logic       mapped;
   logic       wr_take;
   logic [31:0] rd_word;

   // ***********************
   // Setup decode
   // ***********************
   always_comb begin
      win3_is64 = (win3_type == `DMW_TYPE64);
      win2_mask = win2_setup[`DMW_BASE_MSB:`DMW_BASE_LSB];
      win3_mask = win3_setup_lo[`DMW_BASE_MSB:`DMW_BASE_LSB];
      win2_en   = win2_setup[`DMW_EN_BIT];
      win3_en   = win3_setup_lo[`DMW_EN_BIT] &&
                  (!win3_is64 || win3_setup_hi[`DMW_EN_BIT]);
   end

   // Attribute capture from the loaded setup values
   always_ff @(posedge clk) begin
      if (rst) begin
         win2_pref <= 1'b0;
         win3_pref <= 1'b0;
         win3_type <= `DMW_TYPE32;
      end else if (ce) begin
         win2_pref <= win2_setup[`DMW_PREF_BIT];
         win3_pref <= win3_setup_lo[`DMW_PREF_BIT];
         if (win3_setup_lo[`DMW_TYPE_MSB:`DMW_TYPE_LSB] == `DMW_TYPE64) begin
            win3_type <= `DMW_TYPE64;
         end else begin
            win3_type <= `DMW_TYPE32;
         end
      end
   end

   // ***********************
   // Register read mux
   // ***********************
   function automatic logic [31:0] bar_word(input dmw_base_t base, input logic pref,
                                            input dmw_atype_t atype);
      return {base, `DMW_RSVD_VAL, pref, atype, `DMW_SPACE_MEM};
   endfunction

   always_comb begin
      mapped  = 1'b1;
      rd_word = `DMW_WORD_RST;
      unique case (paddr)
         `DMW_OFF_WIN2: rd_word = bar_word(win2_base, win2_pref, `DMW_TYPE32);
         `DMW_OFF_WIN3: rd_word = bar_word(win3_base, win3_pref, win3_type);
         `DMW_OFF_STAT: rd_word = {`DMW_STAT_PAD, win3_is64, win3_en, win2_en};
         default:       mapped  = 1'b0;
      endcase
   end

   // ***********************
   // APB slave
   // ***********************
   assign wr_take = (state == DMW_ACCESS) && psel && penable && pwrite && mapped;

   always_ff @(posedge clk) begin
      if (rst) begin
         state   <= DMW_IDLE;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `DMW_WORD_RST;
      end else if (ce) begin
         unique case (state)
            DMW_IDLE: begin
               if (psel && !penable) begin
                  state   <= DMW_ACCESS;
                  pready  <= 1'b1;
                  pslverr <= !mapped;
                  prdata  <= pwrite ? `DMW_WORD_RST : rd_word;
               end
            end
            DMW_ACCESS: begin
               state   <= DMW_IDLE;
               pready  <= 1'b0;
               pslverr <= 1'b0;
               prdata  <= `DMW_WORD_RST;
            end
         endcase
      end
   end

   // ***********************
   // Base registers
   // ***********************
   dmw_bar_reg u_win2_bar (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .wr_en   (wr_take && (paddr == `DMW_OFF_WIN2)),
      .wr_data (pwdata[`DMW_BASE_MSB:`DMW_BASE_LSB]),
      .wr_mask (win2_mask),
      .base    (win2_base)
   );

   dmw_bar_reg u_win3_bar (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .wr_en   (wr_take && (paddr == `DMW_OFF_WIN3)),
      .wr_data (pwdata[`DMW_BASE_MSB:`DMW_BASE_LSB]),
      .wr_mask (win3_mask),
      .base    (win3_base)
   );

   // ***********************
   // Forwarding windows
   // ***********************
   dmw_xlate u_win2_xlate (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .req_valid (req_valid),
      .req_addr  (req_addr),
      .en        (win2_en),
      .is64      (1'b0),
      .base      (win2_base),
      .mask      (win2_mask),
      .base_hi   (`DMW_WORD_RST),
      .mask_hi   (`DMW_WORD_RST),
      .xlat      (win2_xlat_base[`DMW_BASE_MSB:`DMW_BASE_LSB]),
      .out_valid (win2_valid),
      .hit       (win2_hit),
      .out_addr  (win2_addr)
   );

   dmw_xlate u_win3_xlate (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .req_valid (req_valid),
      .req_addr  (req_addr),
      .en        (win3_en),
      .is64      (win3_is64),
      .base      (win3_base),
      .mask      (win3_mask),
      .base_hi   (win3_upper_base),
      .mask_hi   (win3_setup_hi),
      .xlat      (win3_xlat_base[`DMW_BASE_MSB:`DMW_BASE_LSB]),
      .out_valid (win3_valid),
      .hit       (win3_hit),
      .out_addr  (win3_addr)
   );

   // ***********************
   // Checks
   // ***********************
   a_apb_one_wait: assert property (@(posedge clk) disable iff (rst)
      ce && state == DMW_IDLE && psel && !penable |=> pready ##1 (!pready || !ce))
      else $error("pready not one cycle after setup");
   a_win2_type: assert property (@(posedge clk) disable iff (rst)
      ce && state == DMW_IDLE && psel && !penable && !pwrite && paddr == `DMW_OFF_WIN2
      |=> prdata[`DMW_TYPE_MSB:`DMW_TYPE_LSB] == `DMW_TYPE32)
      else $error("window 2 type not 32-bit");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
      pready && !pslverr |-> prdata[`DMW_RSVD_MSB:`DMW_RSVD_LSB] == `DMW_RSVD_VAL
      && prdata[`DMW_SPACE_BIT] == `DMW_SPACE_MEM)
      else $error("reserved or space bits not zero");
   a_win3_type: assert property (@(posedge clk) disable iff (rst)
      win3_type == `DMW_TYPE32 || win3_type == `DMW_TYPE64)
      else $error("window 3 type reserved code");
   a_pref_follow: assert property (@(posedge clk) disable iff (rst)
      ce |=> win2_pref == $past(win2_setup[`DMW_PREF_BIT]))
      else $error("prefetch flag not following setup");
   a_unmapped_err: assert property (@(posedge clk) disable iff (rst)
      ce && state == DMW_IDLE && psel && !penable && !mapped |=> pslverr && pready)
      else $error("unmapped access without error");
   a_base_reset: assert property (@(posedge clk)
      rst |=> win2_base == `DMW_BASE_RST && win3_base == `DMW_BASE_RST)
      else $error("base not cleared by reset");
endmodule // dmw_top

// [common/dmw_cfg.svh]
// Offsets, field positions and reset values of the memory window registers
`ifndef DMW_CFG_SVH
`define DMW_CFG_SVH
// ***********************
// Register offsets
// ***********************
`define DMW_OFF_WIN2     12'h01c
`define DMW_OFF_WIN3     12'h020
`define DMW_OFF_STAT     12'h0f0
`define DMW_ADDR_MSB     11
// ***********************
// Field positions
// ***********************
`define DMW_SPACE_BIT    0
`define DMW_TYPE_LSB     1
`define DMW_TYPE_MSB     2
`define DMW_PREF_BIT     3
`define DMW_RSVD_LSB     4
`define DMW_RSVD_MSB     11
`define DMW_BASE_LSB     12
`define DMW_BASE_MSB     31
`define DMW_EN_BIT       31
`define DMW_HI_LSB       32
`define DMW_HI_MSB       63
// ***********************
// Codes and reset values
// ***********************
`define DMW_TYPE32       2'h0
`define DMW_TYPE64       2'h1
`define DMW_SPACE_MEM    1'h0
`define DMW_RSVD_VAL     8'h00
`define DMW_BASE_RST     20'h00000
`define DMW_WORD_RST     32'h0000_0000
`define DMW_STAT_PAD     29'h0000_0000
`endif

// [common/dmw_pkg.sv]
// Types and shared functions of the memory window registers
package dmw_pkg;
   typedef logic [19:0] dmw_base_t;
   typedef logic [1:0]  dmw_atype_t;
   typedef enum logic [1:0] {
      DMW_IDLE   = 2'b01,
      DMW_ACCESS = 2'b10
   } dmw_state_t;

   // Take new bits where mask is one, keep old elsewhere
   function automatic dmw_base_t dmw_merge(input dmw_base_t old_v, input dmw_base_t new_v,
                                           input dmw_base_t mask);
      return (old_v & ~mask) | (new_v & mask);
   endfunction

   // Masked equality of two address fields
   function automatic logic dmw_match32(input logic [31:0] a, input logic [31:0] b,
                                        input logic [31:0] mask);
      return ((a ^ b) & mask) == 32'h0000_0000;
   endfunction
endpackage

// [hw/dmw_bar_reg.sv]
// Base field of one window register with per-bit write mask
`timescale 1ns/1ps
`include "dmw_cfg.svh"
module dmw_bar_reg
   import dmw_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst,
   input  wire logic      ce,
   input  wire logic      wr_en,
   input  wire dmw_base_t wr_data,
   input  wire dmw_base_t wr_mask,
   output dmw_base_t      base
);
   // ***********************
   // Base storage
   // ***********************
   always_ff @(posedge clk) begin
      if (rst) begin
         base <= `DMW_BASE_RST;
      end else if (ce && wr_en) begin
         base <= dmw_merge(base, wr_data, wr_mask);
      end
   end

   a_ro_bits_kept: assert property (@(posedge clk) disable iff (rst)
      ce && wr_en |=> ((base ^ $past(base)) & ~$past(wr_mask)) == `DMW_BASE_RST)
      else $error("read-only base bit changed");
   a_rw_bits_taken: assert property (@(posedge clk) disable iff (rst)
      ce && wr_en |=> ((base ^ $past(wr_data)) & $past(wr_mask)) == `DMW_BASE_RST)
      else $error("writable base bit not taken");
endmodule // dmw_bar_reg

// [hw/dmw_xlate.sv]
// Window match and address translation stage
`timescale 1ns/1ps
`include "dmw_cfg.svh"
module dmw_xlate
   import dmw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        req_valid,
   input  wire logic [63:0] req_addr,
   input  wire logic        en,
   input  wire logic        is64,
   input  wire dmw_base_t   base,
   input  wire dmw_base_t   mask,
   input  wire logic [31:0] base_hi,
   input  wire logic [31:0] mask_hi,
   input  wire dmw_base_t   xlat,
   output logic             out_valid,
   output logic             hit,
   output logic [63:0]      out_addr
);
   logic lo_match;
   logic hi_match;
   logic next_hit;
   logic [63:0] next_addr;

   // ***********************
   // Decode
   // ***********************
   always_comb begin
      lo_match = dmw_match32({base, `DMW_RSVD_VAL, 4'h0}, req_addr[31:0],
                             {mask, `DMW_RSVD_VAL, 4'h0});
      hi_match = is64 ? dmw_match32(base_hi, req_addr[`DMW_HI_MSB:`DMW_HI_LSB], mask_hi)
                      : (req_addr[`DMW_HI_MSB:`DMW_HI_LSB] == `DMW_WORD_RST);
      next_hit = en && lo_match && hi_match;
      if (is64) begin
         next_addr = req_addr;
      end else begin
         next_addr = {req_addr[`DMW_HI_MSB:`DMW_HI_LSB],
                      dmw_merge(req_addr[`DMW_BASE_MSB:`DMW_BASE_LSB], xlat, mask),
                      req_addr[`DMW_RSVD_MSB:0]};
      end
   end

   // ***********************
   // Output stage
   // ***********************
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid <= 1'b0;
         hit       <= 1'b0;
         out_addr  <= 64'h0;
      end else if (ce) begin
         out_valid <= req_valid;
         hit       <= req_valid && next_hit;
         out_addr  <= next_addr;
      end
   end

   a_no_hit_off: assert property (@(posedge clk) disable iff (rst)
      ce && req_valid && !en |=> out_valid && !hit)
      else $error("hit on disabled window");
   a_wide_passthru: assert property (@(posedge clk) disable iff (rst)
      ce && req_valid && is64 |=> out_addr == $past(req_addr))
      else $error("64-bit window address altered");
   a_narrow_xlat: assert property (@(posedge clk) disable iff (rst)
      ce && req_valid && !is64 |=>
      ((out_addr[`DMW_BASE_MSB:`DMW_BASE_LSB] ^ $past(xlat)) & $past(mask)) == `DMW_BASE_RST)
      else $error("translated base not applied");
endmodule // dmw_xlate

// [verification/dmw_top_tb_top.sv]
// Self-checking testbench for the memory window base registers
`timescale 1ns/1ps
`include "dmw_cfg.svh"
module dmw_top_tb_top;
   // ***********************
   // Signals and design
   // ***********************
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic [31:0] win2_setup = 32'h0, win2_xlat_base = 32'h0, win3_setup_lo = 32'h0;
   logic [31:0] win3_setup_hi = 32'h0, win3_xlat_base = 32'h0, win3_upper_base = 32'h0;
   logic        req_valid = 1'b0;
   logic [63:0] req_addr = 64'h0;
   logic        win2_valid, win2_hit, win3_valid, win3_hit;
   logic [63:0] win2_addr, win3_addr;
   int          n_fail = 0;
   int          total_checks = 0;
   logic [1:0]  exp_type;

   always #2.5 clk = ~clk;

   dmw_top dmw_top_inst (
      .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .win2_setup(win2_setup), .win2_xlat_base(win2_xlat_base),
      .win3_setup_lo(win3_setup_lo), .win3_setup_hi(win3_setup_hi),
      .win3_xlat_base(win3_xlat_base), .win3_upper_base(win3_upper_base),
      .req_valid(req_valid), .req_addr(req_addr),
      .win2_valid(win2_valid), .win2_hit(win2_hit), .win2_addr(win2_addr),
      .win3_valid(win3_valid), .win3_hit(win3_hit), .win3_addr(win3_addr)
   );

   // ***********************
   // Tasks
   // ***********************
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      logic rdy;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(negedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      rdy = pready;
      q = prdata;
      e = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 64'h1, {63'h0, rdy});
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      chk("write pslverr", {63'h0, err}, {63'h0, e});
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk("read pslverr", {63'h0, err}, {63'h0, e});
      chk("read data", {32'h0, exp}, {32'h0, q});
   endtask

   task automatic dec(input logic [63:0] a, input logic h2, input logic h3,
                      input logic [63:0] x2, input logic [63:0] x3);
      repeat (2) @(posedge clk);
      req_valid <= 1'b1;
      req_addr <= a;
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      chk("win2_valid", 64'h1, {63'h0, win2_valid});
      chk("win3_valid", 64'h1, {63'h0, win3_valid});
      chk("win2_hit", {63'h0, h2}, {63'h0, win2_hit});
      chk("win3_hit", {63'h0, h3}, {63'h0, win3_hit});
      if (h2) chk("win2_addr", x2, win2_addr);
      if (h3) chk("win3_addr", x3, win3_addr);
   endtask

   task automatic wrap_up;
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ***********************
   // Watchdog
   // ***********************
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      wrap_up();
   end

   // ***********************
   // Tests
   // ***********************
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(`DMW_OFF_WIN2, 32'h0000_0000, 1'b0);
      rd(`DMW_OFF_WIN3, 32'h0000_0000, 1'b0);
      // Window 2 with upper twelve base bits writable and prefetchable
      win2_setup <= 32'hfff0_000e;
      win2_xlat_base <= 32'h1230_0000;
      wr(`DMW_OFF_WIN2, 32'hffff_ffff, 1'b0);
      rd(`DMW_OFF_WIN2, 32'hfff0_0008, 1'b0);
      wr(`DMW_OFF_WIN2, 32'ha5a5_a5a5, 1'b0);
      rd(`DMW_OFF_WIN2, 32'ha5a0_0008, 1'b0);
      dec(64'h0000_0000_a5a1_2344, 1'b1, 1'b0, 64'h0000_0000_1231_2344, 64'h0);
      dec(64'h0000_0000_b5a1_2344, 1'b0, 1'b0, 64'h0, 64'h0);
      dec(64'h0000_0001_a5a1_2344, 1'b0, 1'b0, 64'h0, 64'h0);
      // Unmapped place: refused, write dropped
      wr(12'h100, 32'hffff_ffff, 1'b1);
      rd(12'h100, 32'h0000_0000, 1'b1);
      win2_setup <= 32'h7ff0_0008;
      dec(64'h0000_0000_a5a1_2344, 1'b0, 1'b0, 64'h0, 64'h0);
      // Window 3 type codes, reserved ones read as 32-bit
      for (int c = 0; c < 4; c++) begin
         win3_setup_lo <= {29'h0000_0000, c[1:0], 1'b0} | 32'h0000_0008;
         exp_type = (c == 1) ? 2'h1 : 2'h0;
         rd(`DMW_OFF_WIN3, {28'h0000_000, 1'b1, exp_type, 1'b0}, 1'b0);
      end
      // Window 3 in 32-bit mode translates
      win3_setup_lo <= 32'hfff0_0000;
      win3_xlat_base <= 32'h9870_0000;
      wr(`DMW_OFF_WIN3, 32'h3450_0fff, 1'b0);
      rd(`DMW_OFF_WIN3, 32'h3450_0000, 1'b0);
      dec(64'h0000_0000_3456_7890, 1'b0, 1'b1, 64'h0, 64'h0000_0000_9876_7890);
      // Window 3 in 64-bit mode forwards untouched
      win3_setup_lo <= 32'hfff0_0002;
      win3_setup_hi <= 32'hffff_ffff;
      win3_upper_base <= 32'h0000_0012;
      rd(`DMW_OFF_WIN3, 32'h3450_0002, 1'b0);
      dec(64'h0000_0012_3456_7890, 1'b0, 1'b1, 64'h0, 64'h0000_0012_3456_7890);
      dec(64'h0000_0013_3456_7890, 1'b0, 1'b0, 64'h0, 64'h0);
      win3_setup_hi <= 32'h7fff_ffff;
      dec(64'h0000_0012_3456_7890, 1'b0, 1'b0, 64'h0, 64'h0);
      win3_setup_hi <= 32'hffff_ffff;
      win3_setup_lo <= 32'h7ff0_0002;
      dec(64'h0000_0012_3456_7890, 1'b0, 1'b0, 64'h0, 64'h0);
      // Reset clears the written base bits
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(`DMW_OFF_WIN2, 32'h0000_0008, 1'b0);
      wrap_up();
   end
endmodule // dmw_top_tb_top
